// [shared/llc_pkg.sv]
// Constants, register map and field layout of the link control block.
package llc_pkg;
    localparam logic [7:0]  ADR_LINK_CONTROL = 8'h08;
    localparam logic [7:0]  ADR_ISO_CHANNELS = 8'h40;
    localparam logic [7:0]  ADR_CYCLE_TIMER  = 8'h44;
    localparam logic [7:0]  ADR_BUS_NUMBER   = 8'h48;
    localparam logic [31:0] CTRL_RESET       = 32'h0200_0000;
    localparam logic [31:0] CTRL_WMASK       = 32'h1BF0_8C00;
    localparam int BIT_TX_RESET   = 10;
    localparam int BIT_RX_RESET   = 11;
    localparam int BIT_BUSN_CLR   = 15;
    localparam int BIT_RETRY_LO   = 16;
    localparam int BIT_CYC_MASTER = 20;
    localparam int BIT_CYC_SRC    = 21;
    localparam int BIT_CYC_RUN    = 22;
    localparam int BIT_MARK_INS   = 23;
    localparam int BIT_PORT1_EN   = 24;
    localparam int BIT_PORT2_EN   = 25;
    localparam int BIT_CM_CAPABLE = 27;
    localparam int BIT_CM_AUTO    = 28;
    localparam int CHAN_W         = 6;
    localparam int PORT2_LSB      = 8;
    localparam int BUSN_W         = 10;
    localparam logic [9:0]  BUSN_CLEARED  = 10'h3FF;
    localparam int OFFSET_W       = 12;
    localparam int COUNT_W        = 13;
    localparam int OFFSET_WRAP    = 3072;
    localparam int COUNT_WRAP     = 8000;
    localparam logic [15:0] MARK_TAG      = 16'hC0DE;
    typedef enum logic [1:0] {
        RETRY_NEW = 2'b00,
        RETRY_X   = 2'b01,
        RETRY_A   = 2'b10,
        RETRY_B   = 2'b11
    } llc_retry_t;
endpackage

// [hdl/llc_pair_buf.sv]
// Two-entry buffer whose outputs all come straight from flip-flops.
`timescale 1ns/10ps
`default_nettype none
module llc_pair_buf #(
    parameter int W = 32
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         flush,
    // Filling side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [1:0]        v;
        logic [1:0][W-1:0] mem;
    } llc_buf_t;

    llc_buf_t s_r;
    llc_buf_t s_nxt;
    logic     pop;
    logic     push;

    // Entry 0 is always the head; a pop shifts entry 1 down.
    always_comb begin
        s_nxt = s_r;
        pop   = s_r.v[0] & out_ready;
        push  = in_valid & ~s_r.v[1];
        if (pop) begin
            s_nxt.mem[0] = s_r.mem[1];
            s_nxt.v      = {1'b0, s_r.v[1]};
        end
        if (push) begin
            if (!s_nxt.v[0]) begin
                s_nxt.mem[0] = in_data;
                s_nxt.v[0]   = 1'b1;
            end else begin
                s_nxt.mem[1] = in_data;
                s_nxt.v[1]   = 1'b1;
            end
        end
        if (flush) begin
            s_nxt.v = 2'b00;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign in_ready  = ~s_r.v[1];
    assign out_valid = s_r.v[0];
    assign out_data  = s_r.mem[0];
endmodule
`default_nettype wire

// [hdl/llc_cycle_timer.sv]
// Cycle timer with offset and count fields and a selectable cycle source.
`timescale 1ns/10ps
`default_nettype none
module llc_cycle_timer
    import llc_pkg::*;
#(
    parameter int OFS_WRAP = OFFSET_WRAP,
    parameter int CNT_WRAP = COUNT_WRAP
) (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                srst,
    // Control.
    input  wire logic                run,
    input  wire logic                src_ext,
    input  wire logic                ext_edge,
    // Timer state.
    output logic [OFFSET_W-1:0]      offset,
    output logic [COUNT_W-1:0]       count,
    output logic                     count_inc
);
    typedef struct packed {
        logic [OFFSET_W-1:0] ofs;
        logic [COUNT_W-1:0]  cnt;
        logic                inc;
    } llc_tmr_t;

    localparam logic [OFFSET_W-1:0] OFS_LAST = OFFSET_W'(OFS_WRAP - 1);
    localparam logic [COUNT_W-1:0]  CNT_LAST = COUNT_W'(CNT_WRAP - 1);

    llc_tmr_t s_r;
    llc_tmr_t s_nxt;
    logic     bump;

    // Offset runs while enabled; the count follows the chosen source.
    always_comb begin
        s_nxt     = s_r;
        s_nxt.inc = 1'b0;
        bump      = 1'b0;
        if (run) begin
            s_nxt.ofs = (s_r.ofs == OFS_LAST) ? '0 : s_r.ofs + 1'b1;
            if (!src_ext && s_r.ofs == OFS_LAST) begin
                bump = 1'b1;
            end
        end
        if (src_ext && ext_edge) begin
            s_nxt.ofs = '0;
            bump      = 1'b1;
        end
        if (bump) begin
            s_nxt.cnt = (s_r.cnt == CNT_LAST) ? '0 : s_r.cnt + 1'b1;
            s_nxt.inc = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign offset    = s_r.ofs;
    assign count     = s_r.cnt;
    assign count_inc = s_r.inc;
endmodule
`default_nettype wire

// [hdl/llc_link_control.sv]
// Link control register bank with Wishbone slave, cycle timer control and
// isochronous port matching.
`timescale 1ns/10ps
`default_nettype none
module llc_link_control
    import llc_pkg::*;
#(
    parameter int MARK_W = 32
) (
    // Clock and reset.
    input  wire logic              CLK_SYS,
    input  wire logic              SRST,
    // Wishbone classic slave.
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [7:0]        WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic [31:0]            WB_DAT_O,
    output logic                   WB_ACK_O,
    // Physical layer and bus events.
    input  wire logic              PHY_IS_ROOT,
    input  wire logic              LOCAL_BUS_RESET,
    input  wire logic              EXTERNAL_CYCLE_PULSE,
    // Transmitter side.
    input  wire logic              ACK_VALID,
    input  wire logic [1:0]        ACK_RETRY_CODE,
    input  wire logic [1:0]        TX_RETRY_FIELD,
    output logic [1:0]             TX_RETRY_MERGED,
    output logic                   TX_RESET,
    output logic                   CYCLE_START_REQ,
    output logic                   CYCLE_MASTER_ACTIVE,
    // Receiver side.
    output logic                   RX_RESET,
    input  wire logic              ISO_HDR_VALID,
    input  wire logic [CHAN_W-1:0] ISO_CHANNEL,
    output logic                   ISO_ACCEPT,
    input  wire logic              ISO_CYCLE_END,
    // Cycle marks toward the general receive FIFO.
    output logic                   MARK_VALID,
    input  wire logic              MARK_READY,
    output logic [MARK_W-1:0]      MARK_DATA
);
    typedef struct packed {
        logic                ack;
        logic [31:0]         dat;
        logic [31:0]         ctrl;
        logic [1:0]          last_retry;
        logic [CHAN_W-1:0]   port1_chan;
        logic [CHAN_W-1:0]   port2_chan;
        logic [BUSN_W-1:0]   bus_number;
        logic [1:0]          retry_merged;
        logic                tx_rst;
        logic                rx_rst;
        logic                accept;
        logic                cyc_start;
        logic                master_act;
        logic                sync1;
        logic                sync2;
        logic                sync3;
        logic                mark_pend;
        logic [MARK_W-1:0]   mark_word;
    } llc_state_t;

    llc_state_t          s_r;
    llc_state_t          s_nxt;
    logic [OFFSET_W-1:0] tmr_offset;
    logic [COUNT_W-1:0]  tmr_count;
    logic                tmr_inc;
    logic                ext_edge;
    logic                buf_in_ready;
    logic                bus_req;
    logic                wr_req;
    logic [31:0]         wmask;
    logic [31:0]         rdata;

    // Byte-lane mask built from the Wishbone select lines.
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Channel match for one isochronous receive port.
    function automatic logic port_hit(input logic en,
                                      input logic [CHAN_W-1:0] prog,
                                      input logic [CHAN_W-1:0] chan);
        port_hit = en & (prog == chan);
    endfunction

    // Rising edge of the synchronised external cycle pulse.
    assign ext_edge = s_r.sync2 & ~s_r.sync3;

    llc_cycle_timer #(
        .OFS_WRAP (OFFSET_WRAP),
        .CNT_WRAP (COUNT_WRAP)
    ) u_timer (
        .clk       (CLK_SYS),
        .srst      (SRST),
        .run       (s_r.ctrl[BIT_CYC_RUN]),
        .src_ext   (s_r.ctrl[BIT_CYC_SRC]),
        .ext_edge  (ext_edge),
        .offset    (tmr_offset),
        .count     (tmr_count),
        .count_inc (tmr_inc)
    );

    llc_pair_buf #(
        .W (MARK_W)
    ) u_mark_buf (
        .clk       (CLK_SYS),
        .srst      (SRST),
        .flush     (s_r.rx_rst),
        .in_valid  (s_r.mark_pend),
        .in_ready  (buf_in_ready),
        .in_data   (s_r.mark_word),
        .out_valid (MARK_VALID),
        .out_ready (MARK_READY),
        .out_data  (MARK_DATA)
    );

    // Read multiplexer; unmapped addresses and reserved bits read zero.
    always_comb begin
        rdata = '0;
        case (WB_ADR_I)
            ADR_LINK_CONTROL: begin
                rdata = s_r.ctrl & CTRL_WMASK;
                rdata[BIT_RETRY_LO +: 2] = s_r.last_retry;
            end
            ADR_ISO_CHANNELS: begin
                rdata[CHAN_W-1:0] = s_r.port1_chan;
                rdata[PORT2_LSB +: CHAN_W] = s_r.port2_chan;
            end
            ADR_CYCLE_TIMER: begin
                rdata[OFFSET_W-1:0] = tmr_offset;
                rdata[OFFSET_W +: COUNT_W] = tmr_count;
            end
            ADR_BUS_NUMBER: begin
                rdata[BUSN_W-1:0] = s_r.bus_number;
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

    // Next-state logic for the bus slave and all control behaviour.
    always_comb begin
        s_nxt   = s_r;
        bus_req = WB_CYC_I & WB_STB_I & ~s_r.ack;
        wr_req  = bus_req & WB_WE_I;
        wmask   = lane_mask(WB_SEL_I);

        // One-wait-state answer: ack one cycle after the request is seen.
        s_nxt.ack = bus_req;
        s_nxt.dat = bus_req ? rdata : '0;

        // Self-clearing reset bits last exactly one cycle.
        s_nxt.ctrl[BIT_TX_RESET] = 1'b0;
        s_nxt.ctrl[BIT_RX_RESET] = 1'b0;

        // Register writes; only implemented bits are stored.
        if (wr_req) begin
            case (WB_ADR_I)
                ADR_LINK_CONTROL: begin
                    s_nxt.ctrl = ((s_r.ctrl & ~wmask) | (WB_DAT_I & wmask))
                                 & CTRL_WMASK;
                end
                ADR_ISO_CHANNELS: begin
                    if (WB_SEL_I[0]) begin
                        s_nxt.port1_chan = WB_DAT_I[CHAN_W-1:0];
                    end
                    if (WB_SEL_I[1]) begin
                        s_nxt.port2_chan = WB_DAT_I[PORT2_LSB +: CHAN_W];
                    end
                end
                ADR_BUS_NUMBER: begin
                    s_nxt.bus_number = ((s_r.bus_number & ~wmask[BUSN_W-1:0])
                                       | (WB_DAT_I[BUSN_W-1:0] & wmask[BUSN_W-1:0]));
                end
                default: begin
                    s_nxt.dat = s_nxt.dat;
                end
            endcase
        end

        // Reset pulses driven from the stored bits.
        s_nxt.tx_rst = s_nxt.ctrl[BIT_TX_RESET];
        s_nxt.rx_rst = s_nxt.ctrl[BIT_RX_RESET];

        // Bus reset events; hardware load wins over a software write.
        if (LOCAL_BUS_RESET) begin
            if (s_r.ctrl[BIT_BUSN_CLR]) begin
                s_nxt.bus_number = BUSN_CLEARED;
            end
            if (s_r.ctrl[BIT_CM_AUTO] && s_r.ctrl[BIT_CM_CAPABLE] && PHY_IS_ROOT) begin
                s_nxt.ctrl[BIT_CYC_MASTER] = 1'b1;
            end
        end

        // Capture the retry code of each acknowledge and merge it on resend.
        if (ACK_VALID) begin
            s_nxt.last_retry = ACK_RETRY_CODE;
        end
        s_nxt.retry_merged = TX_RETRY_FIELD | s_r.last_retry;

        // Cycle master and cycle-start requests.
        s_nxt.master_act = s_r.ctrl[BIT_CYC_MASTER] & PHY_IS_ROOT;
        s_nxt.cyc_start  = tmr_inc & s_r.master_act;

        // External cycle pulse synchroniser and edge history.
        s_nxt.sync1 = EXTERNAL_CYCLE_PULSE;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;

        // Isochronous channel match on either receive port.
        s_nxt.accept = ISO_HDR_VALID &
            (port_hit(s_r.ctrl[BIT_PORT1_EN], s_r.port1_chan, ISO_CHANNEL) |
             port_hit(s_r.ctrl[BIT_PORT2_EN], s_r.port2_chan, ISO_CHANNEL));

        // Cycle mark waits in a pending slot until the buffer takes it.
        if (s_r.mark_pend && buf_in_ready) begin
            s_nxt.mark_pend = 1'b0;
        end
        if (ISO_CYCLE_END && s_r.ctrl[BIT_MARK_INS]) begin
            s_nxt.mark_pend = 1'b1;
            s_nxt.mark_word = MARK_W'({MARK_TAG, 3'b000, tmr_count});
        end

        // Transmitter reset clears transmit-side state.
        if (s_r.tx_rst) begin
            s_nxt.last_retry   = RETRY_NEW;
            s_nxt.retry_merged = '0;
            s_nxt.cyc_start    = 1'b0;
        end

        // Receiver reset drops accepted headers and pending marks.
        if (s_r.rx_rst) begin
            s_nxt.accept    = 1'b0;
            s_nxt.mark_pend = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            s_r      <= '0;
            s_r.ctrl <= CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flip-flops.
    assign WB_ACK_O            = s_r.ack;
    assign WB_DAT_O            = s_r.dat;
    assign TX_RETRY_MERGED     = s_r.retry_merged;
    assign TX_RESET            = s_r.tx_rst;
    assign RX_RESET            = s_r.rx_rst;
    assign CYCLE_START_REQ     = s_r.cyc_start;
    assign CYCLE_MASTER_ACTIVE = s_r.master_act;
    assign ISO_ACCEPT          = s_r.accept;
endmodule
`default_nettype wire

// [tb/llc_link_control_monitor.sv]
// Concurrent checks on the ports of the link control block.
`timescale 1ns/10ps
`default_nettype none
module llc_link_control_monitor
    import llc_pkg::*;
(
    // Clock, reset and register bus.
    input wire logic        CLK_SYS,
    input wire logic        SRST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic        WB_ACK_O,
    // Transmitter and timer side, and the receiver reset.
    input wire logic        ACK_VALID,
    input wire logic [1:0]  ACK_RETRY_CODE,
    input wire logic [1:0]  TX_RETRY_FIELD,
    input wire logic [1:0]  TX_RETRY_MERGED,
    input wire logic        TX_RESET,
    input wire logic        RX_RESET,
    input wire logic        PHY_IS_ROOT,
    input wire logic        CYCLE_START_REQ,
    input wire logic        CYCLE_MASTER_ACTIVE,
    // Receiver and mark stream.
    input wire logic        ISO_HDR_VALID,
    input wire logic        ISO_ACCEPT,
    input wire logic        MARK_VALID,
    input wire logic        MARK_READY,
    input wire logic [31:0] MARK_DATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // A control write taken by the slave with the given bit set.
    sequence ctl_wr(b);
        WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_ADR_I == ADR_LINK_CONTROL
            && WB_SEL_I[b / 8] && WB_DAT_I[b];
    endsequence
    // An acknowledge followed by a packet with a clean retry field.
    sequence acked;
        ACK_VALID ##1 (TX_RETRY_FIELD == 2'b00 && !TX_RESET);
    endsequence
    tx_reset_pulse_a: assert property (
        ctl_wr(BIT_TX_RESET) |=> TX_RESET ##1 !TX_RESET) else $error("tx reset pulse wrong");
    rx_reset_pulse_a: assert property (
        ctl_wr(BIT_RX_RESET) |=> RX_RESET ##1 !RX_RESET) else $error("rx reset pulse wrong");
    retry_capture_a: assert property (
        acked |=> TX_RETRY_MERGED == $past(ACK_RETRY_CODE, 2)) else $error("retry not captured");
    retry_merge_a: assert property (
        !$past(SRST) |-> (TX_RETRY_MERGED & $past(TX_RETRY_FIELD)) == $past(TX_RETRY_FIELD))
        else $error("packet retry bits lost");
    master_root_a: assert property (
        CYCLE_MASTER_ACTIVE |-> $past(PHY_IS_ROOT)) else $error("master active off root");
    start_master_a: assert property (
        CYCLE_START_REQ |-> CYCLE_MASTER_ACTIVE ##1 !CYCLE_START_REQ) else $error("bad start");
    iso_accept_a: assert property (
        ISO_ACCEPT |-> $past(ISO_HDR_VALID)) else $error("accept without header");
    mark_hold_a: assert property (
        MARK_VALID && !MARK_READY |=> MARK_VALID && $stable(MARK_DATA)) else $error("mark lost");
    mark_tag_a: assert property (
        MARK_VALID |-> MARK_DATA[31:16] == MARK_TAG) else $error("mark tag wrong");
    bus_ack_once_a: assert property (
        WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I && !WB_ACK_O) ##1 !WB_ACK_O)
        else $error("ack not a single answer");
endmodule
bind llc_link_control llc_link_control_monitor u_mon (.CLK_SYS, .SRST, .WB_CYC_I, .WB_STB_I,
    .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_ACK_O, .ACK_VALID, .ACK_RETRY_CODE,
    .TX_RETRY_FIELD, .TX_RETRY_MERGED, .TX_RESET, .RX_RESET, .PHY_IS_ROOT, .CYCLE_START_REQ,
    .CYCLE_MASTER_ACTIVE, .ISO_HDR_VALID, .ISO_ACCEPT, .MARK_VALID, .MARK_READY, .MARK_DATA);
`default_nettype wire

// [tb/llc_phy_model.sv]
// Far-side model that drains cycle marks and can stall the stream.
`timescale 1ns/10ps
`default_nettype none
module llc_phy_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        srst,
    // Mark stream and stall switch.
    input  wire logic        stall,
    input  wire logic        mark_valid,
    input  wire logic [31:0] mark_data,
    output logic             mark_ready,
    output logic [7:0]       mark_cnt,
    output logic [31:0]      mark_last
);
    // Ready follows the stall switch, so the sender must hold its word.
    assign mark_ready = !stall;
    // A word is taken only where valid and ready meet at an edge.
    always_ff @(posedge clk) begin
        if (srst) begin
            mark_cnt <= 8'h00;
            mark_last <= 32'h0000_0000;
        end else if (mark_valid && mark_ready) begin
            mark_cnt <= mark_cnt + 8'h01;
            mark_last <= mark_data;
        end
    end
endmodule
`default_nettype wire

// [tb/llc_link_control_bench.sv]
// Register-level bench for the link control block.
`timescale 1ns/10ps
`default_nettype none
module llc_link_control_bench
    import llc_pkg::*;
;
    logic clk, srst, cyc, stb, we, ack, root, bus_rst, ext, ack_v, tx_rst, cs_req, cm_act;
    logic rx_rst, iso_v, iso_acc, iso_end, mk_v, mk_rdy, stall;
    logic [1:0] ack_code, tx_field, tx_merged;
    logic [7:0] adr, mk_cnt;
    logic [3:0] sel;
    logic [5:0] iso_ch;
    logic [31:0] dat_i, dat_o, mk_d, mk_last, rd, prev;
    int err_count, checks_done, cycles, starts;

    llc_link_control DUT (.CLK_SYS(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .PHY_IS_ROOT(root), .LOCAL_BUS_RESET(bus_rst),
        .EXTERNAL_CYCLE_PULSE(ext), .ACK_VALID(ack_v), .ACK_RETRY_CODE(ack_code),
        .TX_RETRY_FIELD(tx_field), .TX_RETRY_MERGED(tx_merged), .TX_RESET(tx_rst),
        .CYCLE_START_REQ(cs_req), .CYCLE_MASTER_ACTIVE(cm_act), .RX_RESET(rx_rst),
        .ISO_HDR_VALID(iso_v), .ISO_CHANNEL(iso_ch), .ISO_ACCEPT(iso_acc),
        .ISO_CYCLE_END(iso_end), .MARK_VALID(mk_v), .MARK_READY(mk_rdy), .MARK_DATA(mk_d));
    llc_phy_model u_phy (.clk(clk), .srst(srst), .stall(stall), .mark_valid(mk_v),
        .mark_data(mk_d), .mark_ready(mk_rdy), .mark_cnt(mk_cnt), .mark_last(mk_last));

    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Timeout ceiling and cycle-start pulse counter.
    always @(posedge clk) begin
        cycles++;
        if (cs_req === 1'b1) starts++;
        if (cycles == 10000) begin
            err_count++;
            close_out();
        end
    end
    // Compares one value and reports a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One classic Wishbone cycle, held until the slave answers.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        dat_i <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic br();
        @(posedge clk);
        bus_rst <= 1'b1;
        @(posedge clk);
        bus_rst <= 1'b0;
    endtask
    // Header pulse, then the accept seen in the following cycle.
    task automatic iso(input logic [5:0] ch, input logic e);
        @(posedge clk);
        iso_v <= 1'b1;
        iso_ch <= ch;
        @(posedge clk);
        iso_v <= 1'b0;
        @(negedge clk);
        check(32'(iso_acc), 32'(e));
    endtask
    task automatic ends(input int n);
        repeat (n) begin
            @(posedge clk);
            iso_end <= 1'b1;
            @(posedge clk);
            iso_end <= 1'b0;
            tick(3);
        end
    endtask
    task close_out();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence of tests.
    initial begin
        {cyc, stb, we, root, bus_rst, ext, ack_v, iso_v, iso_end, stall} = '0;
        {adr, dat_i, ack_code, tx_field, iso_ch} = '0;
        sel = 4'hF;
        srst = 1'b1;
        tick(2);
        srst <= 1'b0;
        wb(0, ADR_LINK_CONTROL, 0);
        check(rd, CTRL_RESET);
        wb(1, ADR_LINK_CONTROL, 32'hE40C_7380);
        wb(0, ADR_LINK_CONTROL, 0);
        check(rd, 32'h0000_0000);
        wb(0, 8'h20, 0);
        check(rd, 32'h0000_0000);
        $display("test registers done");
        // Even codes leave the packet field clean so the capture check can fire.
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            ack_v <= 1'b1;
            ack_code <= 2'(c);
            tx_field <= 2'((c % 2) * 2);
            @(posedge clk);
            ack_v <= 1'b0;
            tick(2);
            check(32'(tx_merged), 32'(2'(c) | tx_field));
            wb(0, ADR_LINK_CONTROL, 0);
            check(32'(rd[17:16]), 32'(c));
        end
        tx_field <= 2'b00;
        wb(1, ADR_LINK_CONTROL, 32'h0000_0C00);
        wb(0, ADR_LINK_CONTROL, 0);
        check(rd, 32'h0000_0000);
        $display("test retry done");
        wb(1, ADR_BUS_NUMBER, 32'h0000_0005);
        root <= 1'b1;
        br();
        wb(0, ADR_BUS_NUMBER, 0);
        check(rd, 32'h0000_0005);
        wb(1, ADR_LINK_CONTROL, 32'h1800_8000);
        br();
        wb(0, ADR_BUS_NUMBER, 0);
        check(rd, 32'h0000_03FF);
        wb(0, ADR_LINK_CONTROL, 0);
        check(rd, 32'h1810_8000);
        check(32'(cm_act), 32'h1);
        root <= 1'b0;
        tick(3);
        check(32'(cm_act), 32'h0);
        root <= 1'b1;
        $display("test bus reset done");
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        wb(1, ADR_LINK_CONTROL, 32'h0050_0000);
        tick(OFFSET_WRAP + 50);
        wb(0, ADR_CYCLE_TIMER, 0);
        check(32'(rd[24:12]), 32'h1);
        check(32'(starts), 32'h1);
        wb(1, ADR_LINK_CONTROL, 32'h0070_0000);
        ext <= 1'b1;
        tick(8);
        ext <= 1'b0;
        wb(0, ADR_CYCLE_TIMER, 0);
        check(32'(rd[24:12]), 32'h2);
        check(32'(rd[11:0] < 12'd20), 32'h1);
        check(32'(starts), 32'h2);
        wb(1, ADR_LINK_CONTROL, 32'h0020_0000);
        wb(0, ADR_CYCLE_TIMER, 0);
        prev = rd;
        tick(5);
        wb(0, ADR_CYCLE_TIMER, 0);
        check(rd, prev);
        $display("test timer done");
        wb(1, ADR_ISO_CHANNELS, 32'h0000_0905);
        for (int p = 0; p < 2; p++) begin
            wb(1, ADR_LINK_CONTROL, p ? 32'h0280_0000 : 32'h0180_0000);
            iso(6'd5, p == 0);
            iso(6'd9, p == 1);
        end
        @(posedge clk);
        stall <= 1'b1;
        ends(3);
        check(32'(mk_cnt), 32'h0);
        stall <= 1'b0;
        tick(10);
        check(32'(mk_cnt), 32'h3);
        check(mk_last, {MARK_TAG, 3'b000, 13'd2});
        wb(1, ADR_LINK_CONTROL, 32'h0000_0000);
        ends(1);
        tick(5);
        check(32'(mk_cnt), 32'h3);
        $display("test ports and marks done");
        close_out();
    end
endmodule
`default_nettype wire
